// [src/lcg2s_top.sv]
// Gate 2 input select of a configurable logic cell with AXI4-Lite access.
// Assumes the four data signals come from logic on the same clock.
//
// Operation
// - Bit 7 gates fourth data true.
// - Bit 6 gates fourth data inverted.
// - Bit 5 gates third data true.
// - Bit 4 gates third data inverted.
// - Bit 3 gates second data true.
// - Bit 2 gates second data inverted.
// - Bits 1/0 gate first data true/inverted.
// - Cleared bit excludes its term entirely.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module lcg2s_top (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic [lcg2s_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [lcg2s_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [lcg2s_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [lcg2s_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          cell_data_one,
  input  wire logic                          cell_data_two,
  input  wire logic                          cell_data_three,
  input  wire logic                          cell_data_four,
  output logic                               gate2_out
);

  logic [lcg2s_pkg::SEL_W-1:0]  gate2_input_select;
  logic [lcg2s_pkg::NUM_D-1:0]  cell_data;
  logic                         next_gate2;

  logic                         aw_held;
  logic [lcg2s_pkg::ADDR_W-1:0] aw_addr;
  logic                         w_held;
  logic [lcg2s_pkg::SEL_W-1:0]  w_data;
  logic                         w_lane0;
  logic                         do_write;
  logic                         sel_write;
  logic                         do_read;

  // Word-aligned decode; the low two address bits are ignored.
  function automatic logic is_reg(
    input logic [lcg2s_pkg::ADDR_W-1:0] addr,
    input logic [lcg2s_pkg::ADDR_W-1:0] ofs
  );
    is_reg = (addr[lcg2s_pkg::ADDR_W-1:2] == ofs[lcg2s_pkg::ADDR_W-1:2]);
  endfunction

  function automatic logic is_mapped(
    input logic [lcg2s_pkg::ADDR_W-1:0] addr
  );
    is_mapped = is_reg(addr, lcg2s_pkg::OFS_SELECT)
              | is_reg(addr, lcg2s_pkg::OFS_STATUS);
  endfunction

  // Unmapped addresses answer with an error and change nothing.
  function automatic logic [1:0] resp_for(
    input logic [lcg2s_pkg::ADDR_W-1:0] addr
  );
    resp_for = is_mapped(addr) ? lcg2s_pkg::RESP_OKAY
                               : lcg2s_pkg::RESP_SLVERR;
  endfunction

  // Unused bits and unmapped addresses read as zero.
  function automatic logic [lcg2s_pkg::DATA_W-1:0] read_word(
    input logic [lcg2s_pkg::ADDR_W-1:0] addr,
    input logic [lcg2s_pkg::SEL_W-1:0]  select,
    input logic                         gate,
    input logic [lcg2s_pkg::NUM_D-1:0]  data
  );
    read_word = '0;
    if (is_reg(addr, lcg2s_pkg::OFS_SELECT)) begin
      read_word[lcg2s_pkg::SEL_W-1:0] = select;
    end else if (is_reg(addr, lcg2s_pkg::OFS_STATUS)) begin
      read_word[lcg2s_pkg::BIT_STAT_GATE] = gate;
      read_word[lcg2s_pkg::BIT_STAT_DATA +: lcg2s_pkg::NUM_D] = data;
    end
  endfunction

  assign cell_data = {cell_data_four, cell_data_three,
                      cell_data_two, cell_data_one};

  // Address and data are taken independently; one of each may wait.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  // Only byte lane 0 carries the select word; the status word is read only.
  assign sel_write     = do_write & w_lane0
                       & is_reg(aw_addr, lcg2s_pkg::OFS_SELECT);

  // One read at a time; the answer stands from the same edge that accepts the address.
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read       = s_axi_arvalid & s_axi_arready;

  // A held half waits here until its partner arrives.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Only the bits that can reach the register are kept.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      w_data  <= '0;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data  <= s_axi_wdata[lcg2s_pkg::SEL_W-1:0];
      w_lane0 <= s_axi_wstrb[0];
    end
  end

  // The response stands until the master takes it.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_bresp <= lcg2s_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= resp_for(aw_addr);
    end
  end

  // The select word has no defined power-up value, so reset picks a
  // known one; otherwise it changes only by a register write.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      gate2_input_select <= lcg2s_pkg::RST_SELECT;
    end else if (sel_write) begin
      gate2_input_select <= w_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_rresp <= lcg2s_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rresp <= resp_for(s_axi_araddr);
    end
  end

  // The status word samples the gate and data lines at acceptance.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_axi_rdata <= '0;
    end else if (do_read) begin
      s_axi_rdata <= read_word(s_axi_araddr, gate2_input_select,
                               gate2_out, cell_data);
    end
  end

  lcg2s_gate u_gate (
    .select   (gate2_input_select),
    .data     (cell_data),
    .gate_out (next_gate2)
  );

  // Registered so the gate output is glitch free toward the logic core.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      gate2_out <= 1'b0;
    end else begin
      gate2_out <= next_gate2;
    end
  end

endmodule

`default_nettype wire

// [src/lcg2s_pkg.sv]
// Constants shared by the logic cell gate 2 input select block.
// Assumes an AXI4-Lite master with 32-bit data on the system clock.
package lcg2s_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 8;
  localparam int NUM_D  = 4;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

  // Select register fields: true and inverted term per data signal.
  localparam int BIT_D4_TRUE = 7;
  localparam int BIT_D4_INV  = 6;
  localparam int BIT_D3_TRUE = 5;
  localparam int BIT_D3_INV  = 4;
  localparam int BIT_D2_TRUE = 3;
  localparam int BIT_D2_INV  = 2;
  localparam int BIT_D1_TRUE = 1;
  localparam int BIT_D1_INV  = 0;

  // Status register fields.
  localparam int BIT_STAT_GATE = 0;
  localparam int BIT_STAT_DATA = 1;

  // Values after reset.
  localparam logic [SEL_W-1:0] RST_SELECT = 8'h00;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [src/lcg2s_gate.sv]
// Combinational term selection and OR for gate 2 of the logic cell.
// Assumes the data signals and the select word are stable in the clock.
`timescale 1ns/1ns
`default_nettype none

module lcg2s_gate (
  input  wire logic [lcg2s_pkg::SEL_W-1:0] select,
  input  wire logic [lcg2s_pkg::NUM_D-1:0] data,
  output logic                             gate_out
);

  logic [lcg2s_pkg::SEL_W-1:0] terms;

  always_comb begin
    terms = '0;
    terms[lcg2s_pkg::BIT_D4_TRUE] = select[lcg2s_pkg::BIT_D4_TRUE]
                                    & data[3];
    terms[lcg2s_pkg::BIT_D4_INV]  = select[lcg2s_pkg::BIT_D4_INV]
                                    & ~data[3];
    terms[lcg2s_pkg::BIT_D3_TRUE] = select[lcg2s_pkg::BIT_D3_TRUE]
                                    & data[2];
    terms[lcg2s_pkg::BIT_D3_INV]  = select[lcg2s_pkg::BIT_D3_INV]
                                    & ~data[2];
    terms[lcg2s_pkg::BIT_D2_TRUE] = select[lcg2s_pkg::BIT_D2_TRUE]
                                    & data[1];
    terms[lcg2s_pkg::BIT_D2_INV]  = select[lcg2s_pkg::BIT_D2_INV]
                                    & ~data[1];
    terms[lcg2s_pkg::BIT_D1_TRUE] = select[lcg2s_pkg::BIT_D1_TRUE]
                                    & data[0];
    terms[lcg2s_pkg::BIT_D1_INV]  = select[lcg2s_pkg::BIT_D1_INV]
                                    & ~data[0];
  end

  // A cleared select forces its term low, so it cannot affect the OR.
  assign gate_out = |terms;

endmodule

`default_nettype wire

// [testbench/lcg2s_chk.sv]
// Checker for the gate 2 select block; it sees only the top ports.
// Assumes the bench offers write address and data at the same edge.
`timescale 1ns/1ns
`default_nettype none
module lcg2s_chk (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        cell_data_one,
  input wire logic        cell_data_two,
  input wire logic        cell_data_three,
  input wire logic        cell_data_four,
  input wire logic        gate2_out
);
  logic [7:0] sh;
  logic [7:0] wd;
  logic       wr;
  wire logic [7:0] term = {cell_data_four, !cell_data_four, cell_data_three,
    !cell_data_three, cell_data_two, !cell_data_two, cell_data_one,
    !cell_data_one};
  // The shadow lands one edge after the handshake, as the register does.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr <= 1'h0;
      sh <= 8'h00;
    end else begin
      wr <= s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr[3:2] == 2'h0 && s_axi_wstrb[0];
      if (wr) sh <= wd;
    end
  end
  always_ff @(posedge clock) wd <= s_axi_wdata[7:0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  d4_true_a: assert property (
    sh == 8'h80 |=> gate2_out == $past(cell_data_four))
    else $error("gate ignores data four true");
  d4_inv_a: assert property (
    sh == 8'h40 |=> gate2_out != $past(cell_data_four))
    else $error("gate ignores data four inverted");
  d3_true_a: assert property (
    sh == 8'h20 |=> gate2_out == $past(cell_data_three))
    else $error("gate ignores data three true");
  d3_inv_a: assert property (
    sh == 8'h10 |=> gate2_out != $past(cell_data_three))
    else $error("gate ignores data three inverted");
  d2_true_a: assert property (
    sh == 8'h08 |=> gate2_out == $past(cell_data_two))
    else $error("gate ignores data two true");
  d2_inv_a: assert property (
    sh == 8'h04 |=> gate2_out != $past(cell_data_two))
    else $error("gate ignores data two inverted");
  d1_both_a: assert property (
    sh[7:2] == 6'h00 && sh[1:0] != 2'h3 && sh[1:0] != 2'h0
    |=> gate2_out == $past(sh[1] ? cell_data_one : !cell_data_one))
    else $error("gate ignores data one term");
  none_zero_a: assert property (sh == 8'h00 |=> !gate2_out)
    else $error("gate high with no term selected");
  gate_or_a: assert property (gate2_out == $past(|(sh & term)))
    else $error("gate output is not the OR of selected terms");
endmodule
bind lcg2s_top lcg2s_chk u_chk (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .cell_data_one, .cell_data_two, .cell_data_three, .cell_data_four,
  .gate2_out);
`default_nettype wire

// [testbench/logic_cell_gate2_select_tb.sv]
// Self-checking bench for the gate 2 select block over AXI4-Lite.
// Assumes the design answers every channel well within the timeout.
`timescale 1ns/1ns
`default_nettype none
module logic_cell_gate2_select_tb;
  logic        clock = '0, rst_b = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [3:0]  dat = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, gate2_out;
  logic [7:0]  cmb [6] = '{8'hFF, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h81};
  int          n_fail = 0, n_compared = 0, cyc = 0;
  lcg2s_top u_dut (.clock, .rst_b, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cell_data_one(dat[0]),
    .cell_data_two(dat[1]), .cell_data_three(dat[2]),
    .cell_data_four(dat[3]), .gate2_out);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk(32'(g), 32'(e));
  endtask
  task automatic chk_gate(input logic g, input logic e);
    chk(32'(g), 32'(e));
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, where ready is settled.
  task automatic wrc(input logic [3:0] a, s, input logic [31:0] d,
                     input logic [1:0] er);
    logic ka, kw, ta, tw, b;
    logic [1:0] r;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wstrb <= s;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ta && tw)) begin
      @(negedge clock);
      ka = s_axi_awready;
      kw = s_axi_wready;
      @(posedge clock);
      if (ka) s_axi_awvalid <= 1'h0;
      if (kw) s_axi_wvalid <= 1'h0;
      ta |= ka;
      tw |= kw;
    end
    do begin
      @(negedge clock);
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
    end while (!b);
    s_axi_bready <= 1'h0;
    chk_resp(r, er);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    logic k;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clock);
      k = s_axi_arready;
      @(posedge clock);
    end while (!k);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge clock);
      k = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
    end while (!k);
    s_axi_rready <= 1'h0;
    chk(d, ed);
    chk_resp(r, er);
  endtask
  function automatic logic ref_gate(input logic [7:0] s, input logic [3:0] d);
    return |(s & {d[3], !d[3], d[2], !d[2], d[1], !d[1], d[0], !d[0]});
  endfunction
  // Walks all sixteen data patterns, then reads the live status word.
  task automatic gat(input logic [7:0] s);
    for (int d = 0; d < 16; d++) begin
      @(posedge clock);
      dat <= 4'(d);
      @(posedge clock);
      #1 chk_gate(gate2_out, ref_gate(s, 4'(d)));
    end
    rdc(4'h4, {27'h0, 4'hF, ref_gate(s, 4'hF)}, 2'h0);
  endtask
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'h1;
    rdc(4'h0, 32'h0, 2'h0);
    gat(8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wrc(4'h0, 4'h1, 32'h1 << i, 2'h0);
      rdc(4'h0, 32'h1 << i, 2'h0);
      gat(8'h1 << i);
    end
    $display("test single terms done");
    foreach (cmb[j]) begin
      wrc(4'h0, 4'h1, {24'hFFFFFF, cmb[j]}, 2'h0);
      rdc(4'h0, {24'h0, cmb[j]}, 2'h0);
      gat(cmb[j]);
    end
    $display("test combined terms done");
    wrc(4'h8, 4'h1, 32'h0, 2'h2);
    wrc(4'h0, 4'h0, 32'h0, 2'h0);
    wrc(4'h4, 4'h1, 32'h0, 2'h0);
    rdc(4'h0, 32'h81, 2'h0);
    rdc(4'hC, 32'h0, 2'h2);
    gat(8'h81);
    $display("test refused accesses done");
    final_report();
  end
endmodule
`default_nettype wire
